// ### usbnk_pkg.sv
package usbnk_pkg;

  // ***********************************************
  // Register byte offsets
  // ***********************************************
  localparam logic [7:0] NAK_RETRY_DELAY_OFS = 8'h6C;
  localparam logic [7:0] STALL_NAK_FLAGS_OFS = 8'h70;
  localparam logic [7:0] ROUTING_OFS = 8'h74;
  localparam logic [7:0] POWER_OVERRIDE_OFS = 8'h78;
  localparam logic [7:0] PHY_DIRECT_OFS = 8'h7C;
  localparam logic [7:0] PHY_OVERRIDE_EN_OFS = 8'h80;

  // ***********************************************
  // Field positions and widths
  // ***********************************************
  localparam int DELAY_W = 10;
  localparam int FS_WAIT_LSB = 16;
  localparam int LS_WAIT_LSB = 0;
  localparam logic [DELAY_W-1:0] RETRY_WAIT_RST = 10'h010;

  localparam int ROUTE_W = 4;
  localparam int POWER_W = 6;
  localparam int PWR_VBUS_EN = 0;
  localparam int PWR_VBUS_EN_FORCE = 1;
  localparam int PWR_VBUS_DET = 2;
  localparam int PWR_VBUS_DET_FORCE = 3;
  localparam int PWR_OVERCURR = 4;
  localparam int PWR_OVERCURR_FORCE = 5;

  // Direct control register, writable bits and read-only status field
  localparam int DIR_DIFF = 15;
  localparam int DIR_SLEW = 14;
  localparam int DIR_TX_PWRDN = 13;
  localparam int DIR_RX_PWRDN = 12;
  localparam int DIR_DM = 11;
  localparam int DIR_DP = 10;
  localparam int DIR_DM_OE = 9;
  localparam int DIR_DP_OE = 8;
  localparam int DIR_DM_PD = 6;
  localparam int DIR_DM_PU = 5;
  localparam int DIR_DM_HISEL = 4;
  localparam int DIR_DP_PD = 2;
  localparam int DIR_DP_PU = 1;
  localparam int DIR_DP_HISEL = 0;
  localparam int DIR_STATUS_LSB = 16;
  localparam int PHY_STATUS_W = 7;
  localparam logic [31:0] DIRECT_RW_MASK = 32'h0000FF77;

  // Override enable register bit positions
  localparam int OVR_DIFF = 15;
  localparam int OVR_DM_PU = 12;
  localparam int OVR_SLEW = 11;
  localparam int OVR_TX_PWRDN = 10;
  localparam int OVR_RX_PWRDN = 9;
  localparam int OVR_DM = 8;
  localparam int OVR_DP = 7;
  localparam int OVR_DM_OE = 6;
  localparam int OVR_DP_OE = 5;
  localparam int OVR_DM_PD = 4;
  localparam int OVR_DP_PD = 3;
  localparam int OVR_DP_PU = 2;
  localparam int OVR_DM_HISEL = 1;
  localparam int OVR_DP_HISEL = 0;
  localparam logic [31:0] OVERRIDE_RW_MASK = 32'h00009FFF;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int RETRY_UNIT_NS = 1000;
  localparam int CYCLES_PER_US = RETRY_UNIT_NS / CLK_PERIOD_NS;

  // ***********************************************
  // Carriers
  // ***********************************************
  typedef struct packed {
    logic diff;
    logic slew;
    logic tx_pwrdn;
    logic rx_pwrdn;
    logic dm;
    logic dp;
    logic dm_oe;
    logic dp_oe;
    logic dm_pd_en;
    logic dm_pu_en;
    logic dm_hisel;
    logic dp_pd_en;
    logic dp_pu_en;
    logic dp_hisel;
  } usbnk_phy_ctl_t;

  typedef struct packed {
    logic plus_out;
    logic plus_oe;
    logic minus_out;
    logic minus_oe;
  } usbnk_pins_t;

  typedef struct packed {
    logic vbus_detect;
    logic vbus_enable;
    logic overcurrent;
  } usbnk_power_t;

endpackage : usbnk_pkg

// ### usbnk_retry_timer.sv
`timescale 1ns/1ps
`default_nettype none
module usbnk_retry_timer
  import usbnk_pkg::*;
#(
  parameter int WAIT_W = DELAY_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [WAIT_W-1:0] wait_us,
  output logic busy,
  output logic done
);

  localparam int TICK_W = $clog2(CYCLES_PER_US + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLES_PER_US - 1);

  logic [WAIT_W-1:0] us_left_q, us_left_d;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  // A fresh start restarts the wait, so a NAK during a wait extends it
  always_comb
  begin
    us_left_d = us_left_q;
    tick_d = tick_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start)
    begin
      us_left_d = wait_us;
      tick_d = '0;
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      if (us_left_q == '0)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      else if (tick_q == TICK_LAST)
      begin
        tick_d = '0;
        us_left_d = us_left_q - 1'b1;
      end
      else
      begin
        tick_d = tick_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      us_left_q <= '0;
      tick_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      us_left_q <= us_left_d;
      tick_q <= tick_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule : usbnk_retry_timer
`default_nettype wire

// ### usbnk_ctrl.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - As host, after a NAK wait the programmed microseconds before retrying.
// - Full-speed retry wait is bits 25:16 of delay register, reset 0x010.
// - Low-speed retry wait is bits 9:0 of delay register, reset 0x010.
// - Endpoint NAK or STALL sets its flag only when its notify enable is set.
// - Endpoint zero enables come from serial engine control, others from endpoint control.
// - Routing register selects internal, external transceiver or pads, plus soft connect.
// - Power force enable replaces bus sense, bus drive or overcurrent with stored value.
// - Direct PHY controls act only when their override enable bit is set.
// - One override enable bit per PHY signal; cleared leaves controller in charge.
// - Bit 15 selects single-ended or differential; differential ignores minus data and enable.
// - Bit 14 selects low-speed slew at zero, full-speed slew at one.
// - Bits 13 and 12 power down transmitter and receiver when overridden.
// - Differential: plus equals data bit, minus its inverse, gated by plus enable.
// - Single-ended: minus line from bit 11, plus line from bit 10.
// - Enable zero leaves line floating; plus enable covers both lines in differential.
// - Pull-up high select chooses second resistor alone or both resistors together.
// - Summary flag stays high while any endpoint stall/NAK flag is set.
module usbnk_ctrl
  import usbnk_pkg::*;
#(
  parameter int NUM_EP = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_mode,
  input wire logic low_speed_device,
  input wire logic host_nak_received,
  output logic retry_waiting,
  output logic retry_now,
  input wire logic ep_nak_sent,
  input wire logic ep_stall_sent,
  input wire logic [3:0] ep_number,
  input wire logic ep_dir_out,
  input wire logic serial_engine_notify_nak,
  input wire logic serial_engine_notify_stall,
  input wire logic [NUM_EP-1:0] endpoint_notify_nak,
  input wire logic [NUM_EP-1:0] endpoint_notify_stall,
  output logic stall_nak_summary,
  output logic route_internal_transceiver,
  output logic route_external_transceiver,
  output logic route_digital_pads,
  output logic soft_connect,
  input wire usbnk_power_t native_power,
  output usbnk_power_t effective_power,
  input wire usbnk_phy_ctl_t native_phy,
  output usbnk_phy_ctl_t effective_phy,
  output usbnk_pins_t phy_pins,
  input wire logic [PHY_STATUS_W-1:0] phy_status
);

  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic usbnk_phy_ctl_t unpack_direct(input logic [31:0] r);
    usbnk_phy_ctl_t c;
    c.diff = r[DIR_DIFF];
    c.slew = r[DIR_SLEW];
    c.tx_pwrdn = r[DIR_TX_PWRDN];
    c.rx_pwrdn = r[DIR_RX_PWRDN];
    c.dm = r[DIR_DM];
    c.dp = r[DIR_DP];
    c.dm_oe = r[DIR_DM_OE];
    c.dp_oe = r[DIR_DP_OE];
    c.dm_pd_en = r[DIR_DM_PD];
    c.dm_pu_en = r[DIR_DM_PU];
    c.dm_hisel = r[DIR_DM_HISEL];
    c.dp_pd_en = r[DIR_DP_PD];
    c.dp_pu_en = r[DIR_DP_PU];
    c.dp_hisel = r[DIR_DP_HISEL];
    return c;
  endfunction : unpack_direct

  function automatic usbnk_phy_ctl_t unpack_override(input logic [31:0] r);
    usbnk_phy_ctl_t c;
    c.diff = r[OVR_DIFF];
    c.slew = r[OVR_SLEW];
    c.tx_pwrdn = r[OVR_TX_PWRDN];
    c.rx_pwrdn = r[OVR_RX_PWRDN];
    c.dm = r[OVR_DM];
    c.dp = r[OVR_DP];
    c.dm_oe = r[OVR_DM_OE];
    c.dp_oe = r[OVR_DP_OE];
    c.dm_pd_en = r[OVR_DM_PD];
    c.dm_pu_en = r[OVR_DM_PU];
    c.dm_hisel = r[OVR_DM_HISEL];
    c.dp_pd_en = r[OVR_DP_PD];
    c.dp_pu_en = r[OVR_DP_PU];
    c.dp_hisel = r[OVR_DP_HISEL];
    return c;
  endfunction : unpack_override

  function automatic logic pick(input logic en, input logic forced, input logic native);
    return en ? forced : native;
  endfunction : pick

  // ***********************************************
  // Register bus
  // ***********************************************
  logic wr_en;
  logic addr_hit;
  logic [DELAY_W-1:0] fs_wait_q, fs_wait_d;
  logic [DELAY_W-1:0] ls_wait_q, ls_wait_d;
  logic [2*NUM_EP-1:0] flags_q, flags_d;
  logic [2*NUM_EP-1:0] flag_set;
  logic [ROUTE_W-1:0] route_q, route_d;
  logic [POWER_W-1:0] power_q, power_d;
  logic [31:0] direct_q, direct_d;
  logic [31:0] override_q, override_d;

  always_comb
  begin
    case (paddr[7:0])
      NAK_RETRY_DELAY_OFS, STALL_NAK_FLAGS_OFS, ROUTING_OFS, POWER_OVERRIDE_OFS,
      PHY_DIRECT_OFS, PHY_OVERRIDE_EN_OFS: addr_hit = (paddr[11:8] == 4'h0);
      default: addr_hit = 1'b0;
    endcase
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign wr_en = psel && penable && pwrite && addr_hit;

  always_comb
  begin
    prdata = 32'h00000000;
    if (psel && !pwrite)
    begin
      case (paddr[7:0])
        NAK_RETRY_DELAY_OFS:
        begin
          prdata[FS_WAIT_LSB +: DELAY_W] = fs_wait_q;
          prdata[LS_WAIT_LSB +: DELAY_W] = ls_wait_q;
        end
        STALL_NAK_FLAGS_OFS: prdata[2*NUM_EP-1:0] = flags_q;
        ROUTING_OFS: prdata[ROUTE_W-1:0] = route_q;
        POWER_OVERRIDE_OFS: prdata[POWER_W-1:0] = power_q;
        PHY_DIRECT_OFS:
        begin
          prdata = direct_q;
          prdata[DIR_STATUS_LSB +: PHY_STATUS_W] = phy_status;
        end
        PHY_OVERRIDE_EN_OFS: prdata = override_q;
        default: prdata = 32'h00000000;
      endcase
      if (!addr_hit)
      begin
        prdata = 32'h00000000;
      end
    end
  end

  // ***********************************************
  // Endpoint stall/NAK flags
  // ***********************************************
  logic notify_nak;
  logic notify_stall;
  logic [4:0] flag_index;

  always_comb
  begin
    if (ep_number == 4'h0)
    begin
      notify_nak = serial_engine_notify_nak;
      notify_stall = serial_engine_notify_stall;
    end
    else
    begin
      notify_nak = endpoint_notify_nak[ep_number];
      notify_stall = endpoint_notify_stall[ep_number];
    end
    flag_index = {ep_number, ep_dir_out};
    flag_set = '0;
    if (!host_mode && ((ep_nak_sent && notify_nak) || (ep_stall_sent && notify_stall)))
    begin
      flag_set[flag_index] = 1'b1;
    end
  end

  // ***********************************************
  // Register next state
  // ***********************************************
  always_comb
  begin
    fs_wait_d = fs_wait_q;
    ls_wait_d = ls_wait_q;
    route_d = route_q;
    power_d = power_q;
    direct_d = direct_q;
    override_d = override_q;
    flags_d = flags_q;
    if (wr_en)
    begin
      case (paddr[7:0])
        NAK_RETRY_DELAY_OFS:
        begin
          fs_wait_d = pwdata[FS_WAIT_LSB +: DELAY_W];
          ls_wait_d = pwdata[LS_WAIT_LSB +: DELAY_W];
        end
        STALL_NAK_FLAGS_OFS: flags_d = flags_q & ~pwdata[2*NUM_EP-1:0];
        ROUTING_OFS: route_d = pwdata[ROUTE_W-1:0];
        POWER_OVERRIDE_OFS: power_d = pwdata[POWER_W-1:0];
        PHY_DIRECT_OFS: direct_d = pwdata & DIRECT_RW_MASK;
        PHY_OVERRIDE_EN_OFS: override_d = pwdata & OVERRIDE_RW_MASK;
        default: flags_d = flags_q;
      endcase
    end
    // A new event beats a clear in the same cycle
    flags_d = flags_d | flag_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fs_wait_q <= RETRY_WAIT_RST;
      ls_wait_q <= RETRY_WAIT_RST;
      flags_q <= '0;
      route_q <= '0;
      power_q <= '0;
      direct_q <= 32'h00000000;
      override_q <= 32'h00000000;
    end
    else
    begin
      fs_wait_q <= fs_wait_d;
      ls_wait_q <= ls_wait_d;
      flags_q <= flags_d;
      route_q <= route_d;
      power_q <= power_d;
      direct_q <= direct_d;
      override_q <= override_d;
    end
  end

  // ***********************************************
  // NAK retry wait
  // ***********************************************
  logic retry_start;
  logic [DELAY_W-1:0] retry_wait;

  assign retry_start = host_mode && host_nak_received;
  assign retry_wait = low_speed_device ? ls_wait_q : fs_wait_q;

  usbnk_retry_timer #(
    .WAIT_W(DELAY_W)
  ) u_retry_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(retry_start),
    .wait_us(retry_wait),
    .busy(retry_waiting),
    .done(retry_now)
  );

  // ***********************************************
  // Output stage
  // ***********************************************
  usbnk_phy_ctl_t forced_phy;
  usbnk_phy_ctl_t ovr_en;
  usbnk_phy_ctl_t phy_d, phy_q;
  usbnk_pins_t pins_d, pins_q;
  usbnk_power_t power_eff_d, power_eff_q;

  always_comb
  begin
    forced_phy = unpack_direct(direct_q);
    ovr_en = unpack_override(override_q);
    // Per-signal mux keeps unselected signals under controller control
    phy_d = (forced_phy & ovr_en) | (native_phy & ~ovr_en);
    if (phy_d.diff)
    begin
      // Minus data and its enable are ignored in differential drive
      pins_d.plus_out = phy_d.dp;
      pins_d.minus_out = ~phy_d.dp;
      pins_d.plus_oe = phy_d.dp_oe;
      pins_d.minus_oe = phy_d.dp_oe;
    end
    else
    begin
      pins_d.plus_out = phy_d.dp;
      pins_d.minus_out = phy_d.dm;
      pins_d.plus_oe = phy_d.dp_oe;
      pins_d.minus_oe = phy_d.dm_oe;
    end
    // Value bits are stored separately so writing them first avoids a glitch
    power_eff_d.vbus_detect = pick(power_q[PWR_VBUS_DET_FORCE], power_q[PWR_VBUS_DET],
                                   native_power.vbus_detect);
    power_eff_d.vbus_enable = pick(power_q[PWR_VBUS_EN_FORCE], power_q[PWR_VBUS_EN],
                                   native_power.vbus_enable);
    power_eff_d.overcurrent = pick(power_q[PWR_OVERCURR_FORCE], power_q[PWR_OVERCURR],
                                   native_power.overcurrent);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phy_q <= '0;
      pins_q <= '0;
      power_eff_q <= '0;
    end
    else
    begin
      phy_q <= phy_d;
      pins_q <= pins_d;
      power_eff_q <= power_eff_d;
    end
  end

  assign effective_phy = phy_q;
  assign phy_pins = pins_q;
  assign effective_power = power_eff_q;
  assign stall_nak_summary = |flags_q;
  assign route_internal_transceiver = route_q[0];
  assign route_external_transceiver = route_q[1];
  assign route_digital_pads = route_q[2];
  assign soft_connect = route_q[3];

endmodule : usbnk_ctrl
`default_nettype wire

// ### usbnk_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port-level checker
// ****************************************
module usbnk_ctrl_monitor
  import usbnk_pkg::*;
#(
  parameter int NUM_EP = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic host_mode,
  input wire logic host_nak_received,
  input wire logic retry_waiting,
  input wire logic retry_now,
  input wire logic ep_nak_sent,
  input wire logic ep_stall_sent,
  input wire logic [3:0] ep_number,
  input wire logic serial_engine_notify_nak,
  input wire logic stall_nak_summary,
  input wire usbnk_phy_ctl_t effective_phy,
  input wire usbnk_pins_t phy_pins
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ev_d, ev_q, wr_d, wr_q;
  // Remember last cycle's causes so a flag edge can be traced back to them
  always_comb
  begin
    ev_d = !host_mode && (ep_nak_sent || ep_stall_sent);
    wr_d = psel && penable && pwrite && paddr == {4'h0, STALL_NAK_FLAGS_OFS};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      ev_q <= ev_d;
      wr_q <= wr_d;
    end
  end
  property p_ep0_flag;
    !host_mode && ep_nak_sent && ep_number == 4'h0 && serial_engine_notify_nak |=> stall_nak_summary;
  endproperty
  property p_sum_rise;
    $rose(stall_nak_summary) |-> ev_q;
  endproperty
  property p_sum_fall;
    $fell(stall_nak_summary) |-> wr_q;
  endproperty
  property p_retry_start;
    host_mode && host_nak_received |=> retry_waiting;
  endproperty
  property p_retry_end;
    $fell(retry_waiting) |-> retry_now;
  endproperty
  property p_retry_pulse;
    retry_now |=> !retry_now;
  endproperty
  property p_diff_pins;
    effective_phy.diff && $stable(effective_phy) |-> phy_pins ==
      {effective_phy.dp, effective_phy.dp_oe, ~effective_phy.dp, effective_phy.dp_oe};
  endproperty
  property p_se_pins;
    !effective_phy.diff && $stable(effective_phy) |-> phy_pins ==
      {effective_phy.dp, effective_phy.dp_oe, effective_phy.dm, effective_phy.dm_oe};
  endproperty
  a_ep0_flag: assert property (p_ep0_flag)
    else $error("endpoint zero nak not flagged");
  a_sum_rise: assert property (p_sum_rise)
    else $error("summary rose without enabled event");
  a_sum_fall: assert property (p_sum_fall)
    else $error("summary fell without flag write");
  a_retry_start: assert property (p_retry_start)
    else $error("retry wait did not start");
  a_retry_end: assert property (p_retry_end)
    else $error("retry wait ended without retry pulse");
  a_retry_pulse: assert property (p_retry_pulse)
    else $error("retry pulse longer than one cycle");
  a_diff_pins: assert property (p_diff_pins)
    else $error("differential pin drive wrong");
  a_se_pins: assert property (p_se_pins)
    else $error("single-ended pin drive wrong");
  c_retry: cover property (retry_now);
  c_flag: cover property ($rose(stall_nak_summary));
  c_diff: cover property (effective_phy.diff && effective_phy.dp_oe);
endmodule : usbnk_ctrl_monitor
bind usbnk_ctrl usbnk_ctrl_monitor #(.NUM_EP(NUM_EP)) mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .host_mode(host_mode), .host_nak_received(host_nak_received),
  .retry_waiting(retry_waiting), .retry_now(retry_now), .ep_nak_sent(ep_nak_sent), .ep_stall_sent(ep_stall_sent),
  .ep_number(ep_number), .serial_engine_notify_nak(serial_engine_notify_nak),
  .stall_nak_summary(stall_nak_summary), .effective_phy(effective_phy), .phy_pins(phy_pins));
`default_nettype wire

// ### usbnk_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Transceiver line model
// ****************************************
module usbnk_phy_model
  import usbnk_pkg::*;
(
  input wire logic pclk,
  input wire usbnk_pins_t pins,
  output logic [PHY_STATUS_W-1:0] status
);
  logic dp_q = 1'b0;
  logic dm_q = 1'b0;
  // A released line toggles so a stale value can never look valid
  always @(posedge pclk)
  begin
    dp_q <= pins.plus_oe ? pins.plus_out : ~dp_q;
    dm_q <= pins.minus_oe ? pins.minus_out : ~dm_q;
  end
  assign status = {4'h0, dm_q, dp_q, dp_q & ~dm_q};
endmodule : usbnk_phy_model
`default_nettype wire

// ### test_usb_phy_override_and_nak_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_usb_phy_override_and_nak_control
  import usbnk_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic host_mode, low_speed_device, host_nak_received, retry_waiting, retry_now;
  logic ep_nak_sent, ep_stall_sent, ep_dir_out, sn, ss, hm, stall_nak_summary;
  logic serial_engine_notify_nak, serial_engine_notify_stall;
  logic [3:0] ep_number;
  logic [15:0] endpoint_notify_nak, endpoint_notify_stall, nk, sk;
  logic route_internal_transceiver, route_external_transceiver, route_digital_pads, soft_connect;
  usbnk_power_t native_power, effective_power;
  usbnk_phy_ctl_t native_phy, effective_phy, px;
  usbnk_pins_t phy_pins;
  logic [6:0] phy_status, st_at;
  logic [13:0] ov;
  logic [31:0] m [6];
  logic [31:0] wm [6];
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int k, ep, dir, st;
  usbnk_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_mode(host_mode), .low_speed_device(low_speed_device), .host_nak_received(host_nak_received),
    .retry_waiting(retry_waiting), .retry_now(retry_now), .ep_nak_sent(ep_nak_sent),
    .ep_stall_sent(ep_stall_sent), .ep_number(ep_number), .ep_dir_out(ep_dir_out),
    .serial_engine_notify_nak(serial_engine_notify_nak), .serial_engine_notify_stall(serial_engine_notify_stall),
    .endpoint_notify_nak(endpoint_notify_nak), .endpoint_notify_stall(endpoint_notify_stall),
    .stall_nak_summary(stall_nak_summary), .route_internal_transceiver(route_internal_transceiver),
    .route_external_transceiver(route_external_transceiver), .route_digital_pads(route_digital_pads),
    .soft_connect(soft_connect), .native_power(native_power), .effective_power(effective_power),
    .native_phy(native_phy), .effective_phy(effective_phy), .phy_pins(phy_pins), .phy_status(phy_status));
  usbnk_phy_model phy_u (.pclk(pclk), .pins(phy_pins), .status(phy_status));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic final_report();
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input int i, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 12'h06C + 12'(4 * i);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    st_at = phy_status;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, i, d);
    if (i == 1)
      m[1] = m[1] & ~d;
    else
      m[i] = d & wm[i];
  endtask : wr
  task automatic rd(input int i);
    apb(1'b0, i, 32'h0);
    chk(r, (i == 4) ? m[4] | {9'h0, st_at, 16'h0} : m[i]);
  endtask : rd
  function automatic logic [13:0] osel(input logic [31:0] o);
    return {o[15], o[11:5], o[4], o[12], o[1], o[3], o[2], o[0]};
  endfunction : osel
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {host_mode, low_speed_device, host_nak_received, ep_nak_sent, ep_stall_sent, ep_number} = '0;
    {ep_dir_out, serial_engine_notify_nak, serial_engine_notify_stall} = '0;
    {endpoint_notify_nak, endpoint_notify_stall, native_power, native_phy} = '0;
    m = '{32'h00100010, 0, 0, 0, 0, 0};
    wm = '{32'h03FF03FF, 0, 32'hF, 32'h3F, DIRECT_RW_MASK, OVERRIDE_RW_MASK};
    void'($urandom(32'h38693659));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) rd(i);
    apb(1'b0, 6, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      wr(i, $urandom());
      rd(i);
    end
    chk({soft_connect, route_digital_pads, route_external_transceiver, route_internal_transceiver}, m[2]);
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom();
      native_power <= 3'($urandom());
      wr(3, (m[3] & 32'h2A) | (v & 32'h15));
      wr(3, v);
      // Outputs are registered, so they follow a write one cycle after it lands
      @(posedge pclk);
      chk(effective_power, {m[3][3] ? m[3][2] : native_power.vbus_detect, m[3][1] ? m[3][0] :
        native_power.vbus_enable, m[3][5] ? m[3][4] : native_power.overcurrent});
      native_phy <= 14'($urandom());
      wr(5, $urandom());
      wr(4, $urandom());
      @(posedge pclk);
      ov = osel(m[5]);
      px = ({m[4][15:8], m[4][6:4], m[4][2:0]} & ov) | (native_phy & ~ov);
      chk(effective_phy, px);
      chk(phy_pins, {px.dp, px.dp_oe, px.diff ? ~px.dp : px.dm, px.diff ? px.dp_oe : px.dm_oe});
      rd(4);
    end
    for (int i = 0; i < 48; i++)
    begin
      ep = (i % 8 == 0) ? 0 : $urandom_range(15, 0);
      dir = $urandom_range(1, 0);
      st = $urandom_range(1, 0);
      hm = ($urandom_range(3, 0) == 0);
      {sn, ss, nk, sk} = 34'($urandom()) ^ 34'($urandom() << 2);
      host_mode <= hm;
      {serial_engine_notify_nak, serial_engine_notify_stall} <= {sn, ss};
      {endpoint_notify_nak, endpoint_notify_stall} <= {nk, sk};
      {ep_number, ep_dir_out, ep_nak_sent, ep_stall_sent} <= {4'(ep), dir[0], !st[0], st[0]};
      @(posedge pclk);
      {ep_nak_sent, ep_stall_sent} <= 2'b00;
      if (!hm && (ep == 0 ? (st ? ss : sn) : (st ? sk[ep] : nk[ep])))
        m[1][2 * ep + dir] = 1'b1;
      @(posedge pclk);
      if (i % 8 == 7)
      begin
        rd(1);
        chk(stall_nak_summary, |m[1]);
        wr(1, $urandom());
        rd(1);
      end
    end
    wr(1, 32'hFFFFFFFF);
    chk(stall_nak_summary, 32'h0);
    host_mode <= 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      wr(0, ((j + 1) << 16) | (j / 2));
      low_speed_device <= j[0];
      host_nak_received <= 1'b1;
      @(posedge pclk);
      host_nak_received <= 1'b0;
      k = 0;
      do
      begin
        @(negedge pclk);
        k++;
      end
      while (retry_now !== 1'b1 && k < 400);
      chk(32'(k), 32'((j[0] ? j / 2 : j + 1) * CYCLES_PER_US + 2));
      @(posedge pclk);
    end
    final_report();
  end
endmodule : test_usb_phy_override_and_nak_control
`default_nettype wire
